/* hdl/sequencer_compare_unit.sv */
// Sequencer compare engine with an Avalon-MM register slave.
// Assumes rung and source are synchronous to ref_clk; one clock is one scan.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module sequencer_compare_unit #(
  parameter int unsigned STEPS = 256
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic [seq_cmp_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [seq_cmp_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [seq_cmp_pkg::DATA_W-1:0]     avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          rung,
  input  wire logic [31:0]                   source_word,
  output logic                               found_flag,
  output logic                               done_flag,
  output logic                               minor_fault_flag,
  output logic                               irq
);
  import seq_cmp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_e         bus_state;
  logic               enable_flag;
  logic               error_flag;
  logic [15:0]        length_word;
  logic [15:0]        position_word;
  logic [1:0]         config_bits;
  logic [31:0]        imm_mask;
  logic [31:0]        ref_table  [STEPS];
  logic [31:0]        mask_table [STEPS];
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic               rung_prev;
  logic               rung_rise;
  logic               bus_req;
  logic               bus_do;
  logic               wr_do;
  logic [31:0]        wr_val;
  logic               sel_tab_ref;
  logic               sel_tab_mask;
  logic [7:0]         tab_addr;
  logic [15:0]        pos_limit;
  logic               bad_config;
  logic [15:0]        stepped;
  logic               take_step;
  logic [15:0]        next_position;
  logic               err_now;
  logic [7:0]         index;
  logic [31:0]        ref_entry;
  logic [31:0]        mask_entry;
  logic               match;
  logic [IRQ_W-1:0]   irq_event;
  logic [15:0]        status_word;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Every access waits one cycle so read data can come from a flop
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & (bus_state != BUS_ACK);
  assign bus_do          = bus_req & (bus_state == BUS_ACK);
  assign wr_do           = bus_do & avs_write;
  assign sel_tab_ref     = (avs_address[11:10] == TAB_SEL_BITS_REF);
  assign sel_tab_mask    = (avs_address[11:10] == TAB_SEL_BITS_MASK);
  assign tab_addr        = avs_address[9:2];

  // Byte lanes merge new data over the addressed register's old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Handshake state: request seen, then answer one cycle later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= BUS_ACK;
          end
        end
        BUS_ACK: bus_state <= BUS_IDLE;
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end

  // Status word packs the flags at their fixed bit positions
  always_comb begin
    status_word             = 16'h0000;
    status_word[BIT_ENABLE] = enable_flag;
    status_word[BIT_DONE]   = done_flag;
    status_word[BIT_ERROR]  = error_flag;
    status_word[BIT_FOUND]  = found_flag;
  end

  // Read data registered on the waiting cycle; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state == BUS_IDLE) begin
      if (sel_tab_ref) begin
        avs_readdata <= ref_table[tab_addr];
      end else if (sel_tab_mask) begin
        avs_readdata <= mask_table[tab_addr];
      end else begin
        case (avs_address)
          OFS_STATUS:     avs_readdata <= {16'h0000, status_word};
          OFS_LENGTH:     avs_readdata <= {16'h0000, length_word};
          OFS_POSITION:   avs_readdata <= {16'h0000, position_word};
          OFS_CONFIG:     avs_readdata <= {30'h0000_0000, config_bits};
          OFS_IMM_MASK:   avs_readdata <= imm_mask;
          OFS_IRQ_STATUS: avs_readdata <= {29'h0000_0000, irq_status};
          OFS_IRQ_MASK:   avs_readdata <= {29'h0000_0000, irq_mask};
          default:        avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference and mask tables
  // ----------------------------------------------------------------
  // Tables hold no reset; software loads them before enabling the rung
  always_ff @(posedge ref_clk) begin
    if (wr_do && sel_tab_ref) begin
      ref_table[tab_addr] <= merge(ref_table[tab_addr], avs_writedata, avs_byteenable);
    end
    if (wr_do && sel_tab_mask) begin
      mask_table[tab_addr] <= merge(mask_table[tab_addr], avs_writedata, avs_byteenable);
    end
  end

  // Configuration: data size and mask source, plus the immediate mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_bits <= CONFIG_RST;
      imm_mask    <= IMM_MASK_RST;
      irq_mask    <= '0;
    end else if (wr_do) begin
      case (avs_address)
        OFS_CONFIG:   config_bits <= avs_writedata[1:0] & {2{avs_byteenable[0]}} |
                                     config_bits & {2{~avs_byteenable[0]}};
        OFS_IMM_MASK: imm_mask <= merge(imm_mask, avs_writedata, avs_byteenable);
        OFS_IRQ_MASK: irq_mask <= avs_byteenable[0] ? avs_writedata[IRQ_W-1:0] : irq_mask;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Rung edge and stepping
  // ----------------------------------------------------------------
  // Previous scan's rung state gives the false-to-true edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rung_prev <= 1'b0;
    end else begin
      rung_prev <= rung;
    end
  end
  assign rung_rise = rung & ~rung_prev;

  assign pos_limit = config_bits[CFG_LONG] ? POS_MAX_LONG : POS_MAX_WORD;
  // Length outside one to 256, or a negative word, blocks stepping
  assign bad_config = position_word[15] | length_word[15] | (length_word == 16'h0000) |
                      (length_word > LEN_MAX) | (position_word > pos_limit);
  // After the last step the next rise restarts at step one
  assign stepped   = done_flag ? 16'h0001 : position_word + 16'h0001;
  assign take_step = rung_rise & ~bad_config & (stepped <= pos_limit);
  assign next_position = take_step ? stepped : position_word;
  assign err_now   = bad_config | (rung_rise & (stepped > pos_limit));

  // Compare uses the stepped position in the same scan as the rise
  assign index      = next_position[7:0];
  assign ref_entry  = ref_table[index];
  assign mask_entry = config_bits[CFG_MTAB] ? mask_table[index] : imm_mask;

  mask_compare u_cmp (
    .long_word (config_bits[CFG_LONG]),
    .reference (ref_entry),
    .source    (source_word),
    .mask      (mask_entry),
    .match     (match)
  );

  // Position and length: the hardware step beats a software write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      position_word <= POSITION_RST;
      length_word   <= LENGTH_RST;
    end else begin
      if (take_step) begin
        position_word <= next_position;
      end else if (wr_do && avs_address == OFS_POSITION) begin
        position_word <= merge({16'h0000, position_word}, avs_writedata, avs_byteenable)
                         [15:0];
      end
      if (wr_do && avs_address == OFS_LENGTH) begin
        length_word <= merge({16'h0000, length_word}, avs_writedata, avs_byteenable)
                       [15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Enable follows the rung: set on the rise, dropped when it goes false
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_flag <= 1'b0;
    end else if (rung_rise) begin
      enable_flag <= 1'b1;
    end else if (!rung) begin
      enable_flag <= 1'b0;
    end
  end

  // Done is judged only when a step is taken, so a rise that takes no step leaves it unchanged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (take_step) begin
      done_flag <= (stepped >= length_word);
    end
  end

  // Found tracks the masked compare every scan while the rung is true
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      found_flag <= 1'b0;
    end else if (rung) begin
      found_flag <= match;
    end
  end

  // Error mirrors the current fault; minor fault stays until cleared
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_flag       <= 1'b0;
      minor_fault_flag <= 1'b0;
    end else begin
      error_flag <= err_now;
      if (err_now) begin
        minor_fault_flag <= 1'b1;
      end else if (wr_do && avs_address == OFS_STATUS && avs_byteenable[1] &&
                   avs_writedata[BIT_ERROR]) begin
        minor_fault_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_event[IRQ_DONE]  = take_step & (stepped >= length_word);
  assign irq_event[IRQ_FOUND] = rung & match & ~found_flag;
  assign irq_event[IRQ_ERROR] = err_now & ~error_flag;

  // Sticky bits, write one to clear; a new event wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (wr_do && avs_address == OFS_IRQ_STATUS && avs_byteenable[0]) begin
      irq_status <= (irq_status & ~avs_writedata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rise_ok;
    !rung_prev && rung && !bad_config && !done_flag && (position_word < pos_limit);
  endsequence
  sequence s_rise_after_done;
    !rung_prev && rung && !bad_config && done_flag;
  endsequence

  a_rise_steps_pos: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_rise_ok |=> position_word == $past(position_word) + 16'h0001)
    else $error("position did not step on rung rise");
  a_restart_step_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_rise_after_done |=> position_word == 16'h0001 && done_flag == ($past(length_word) <= 16'h0001))
    else $error("position did not restart at step one");
  a_found_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rung |=> found_flag == ((($past(ref_entry) ^ $past(source_word)) & $past(mask_entry) &
      ($past(config_bits[CFG_LONG]) ? 32'hffff_ffff : WORD_MASK)) == 32'h0000_0000))
    else $error("found flag disagrees with masked compare");
  a_found_holds_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rung |=> $stable(found_flag))
    else $error("found flag changed while rung false");
  a_enable_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rung_rise |=> enable_flag ##1 (enable_flag || !$past(rung)))
    else $error("enable flag not set by rung rise");
  a_done_at_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_step && stepped == length_word |=> done_flag && status_word[BIT_DONE])
    else $error("done flag missing after last step");
  a_error_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (length_word == 16'h0000 || position_word[15]) |=> error_flag && minor_fault_flag)
    else $error("error or minor fault not raised");
  a_pos_in_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_step |=> position_word <= ($past(config_bits[CFG_LONG]) ? POS_MAX_LONG : POS_MAX_WORD))
    else $error("position stepped past its limit");
  a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule

`default_nettype wire

/* include/seq_cmp_pkg.sv */
// Constants shared by the sequencer compare unit and its comparator.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package seq_cmp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LENGTH     = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_POSITION   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CONFIG     = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_IMM_MASK   = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 12'h018;
  localparam logic [ADDR_W-1:0] BASE_REF_TAB   = 12'h400;
  localparam logic [ADDR_W-1:0] BASE_MASK_TAB  = 12'h800;
  localparam logic [1:0]        TAB_SEL_BITS_REF  = 2'h1;
  localparam logic [1:0]        TAB_SEL_BITS_MASK = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_DONE   = 13;
  localparam int unsigned BIT_ERROR  = 11;
  localparam int unsigned BIT_FOUND  = 8;
  localparam int unsigned CFG_LONG   = 0;
  localparam int unsigned CFG_MTAB   = 1;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_FOUND  = 1;
  localparam int unsigned IRQ_ERROR  = 2;
  localparam int unsigned IRQ_W      = 3;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] LENGTH_RST   = 16'h0001;
  localparam logic [15:0] POSITION_RST = 16'h0000;
  localparam logic [1:0]  CONFIG_RST   = 2'h0;
  localparam logic [31:0] IMM_MASK_RST = 32'h0000_ffff;
  localparam logic [15:0] LEN_MAX      = 16'h0100;
  localparam logic [15:0] POS_MAX_WORD = 16'h00ff;
  localparam logic [15:0] POS_MAX_LONG = 16'h007f;
  localparam logic [31:0] WORD_MASK    = 32'h0000_ffff;

  // Bus answer sequencing
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage

/* hdl/mask_compare.sv */
// Masked equality of a source word against a reference entry.
// Assumes the caller picks the mask (immediate or table entry).
`timescale 1ns/10ps
`default_nettype none

module mask_compare (
  input  wire logic        long_word,
  input  wire logic [31:0] reference,
  input  wire logic [31:0] source,
  input  wire logic [31:0] mask,
  output logic             match
);
  import seq_cmp_pkg::*;

  logic [31:0] eff_mask;

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------
  // Word data ignores the upper half so stray high bits never count
  assign eff_mask = long_word ? mask : (mask & WORD_MASK);
  // Mask applies to both sides; a zero bit drops that position
  assign match = ((reference & eff_mask) == (source & eff_mask));

endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the sequencer compare unit.
// Assumes the unit answers each bus access by dropping waitrequest and scans once per clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import seq_cmp_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              ref_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              rung;
  logic [31:0]       source_word;
  logic              found_flag;
  logic              done_flag;
  logic              minor_fault_flag;
  logic              irq;
  int                fails;
  int                tests_run;
  logic [31:0]       rd;

  sequencer_compare_unit #(.STEPS(256)) dut (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .rung             (rung),
    .source_word      (source_word),
    .found_flag       (found_flag),
    .done_flag        (done_flag),
    .minor_fault_flag (minor_fault_flag),
    .irq              (irq)
  );

  // ----------------------------------------------------------------
  // Clock, verdict and checks
  // ----------------------------------------------------------------
  // 100 MHz scan clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access; request held until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      fails++;
      finish_test();
    end else begin
      // Taking edge: data captured and request released at this same edge
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Read and compare under a field mask
  task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(name, exp & m, rd & m);
  endtask

  // Rung goes true; the rise is judged at the following edge
  task automatic rise();
    @(posedge ref_clk);
    rung <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Rung false for two scans, so the next rise is legal
  task automatic fall();
    @(posedge ref_clk);
    rung <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic set_src(input logic [31:0] v);
    @(posedge ref_clk);
    source_word <= v;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  localparam logic [31:0] ST_EN = 32'h1 << BIT_ENABLE;
  localparam logic [31:0] ST_DN = 32'h1 << BIT_DONE;
  localparam logic [31:0] ST_ER = 32'h1 << BIT_ERROR;
  localparam logic [31:0] ST_FD = 32'h1 << BIT_FOUND;
  localparam logic [31:0] ALL   = 32'hffff_ffff;
  logic [ADDR_W-1:0] rst_a [7];
  logic [31:0]       rst_v [7];
  logic [15:0]       bad_len [2];

  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    rung = 1'b0;
    source_word = 32'h0;
    rst_a = '{OFS_STATUS, OFS_LENGTH, OFS_POSITION, OFS_CONFIG, OFS_IMM_MASK, OFS_IRQ_STATUS, 12'h020};
    rst_v = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0000_ffff, 32'h0, 32'h0};
    bad_len = '{16'h0000, 16'h0101};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values, including an unmapped place that reads zero
    for (int i = 0; i < 7; i++) begin
      rchk("reset value", rst_a[i], rst_v[i], ALL);
    end
    // Three-step table with a fixed mask that ignores the low nibble
    wr(BASE_REF_TAB + 12'h004, 32'h2490);
    wr(BASE_REF_TAB + 12'h008, 32'h1234);
    wr(BASE_REF_TAB + 12'h00c, 32'h00ff);
    wr(OFS_LENGTH, 32'h3);
    wr(OFS_IMM_MASK, 32'hfff0);
    source_word <= 32'h249f;
    rise();
    chk("found step1", 1'b1, found_flag);
    rchk("position step1", OFS_POSITION, 32'h1, ALL);
    rchk("status step1", OFS_STATUS, ST_EN | ST_FD, ALL);
    set_src(32'h2480);
    chk("found recompare", 1'b0, found_flag);
    set_src(32'h2491);
    chk("found masked nibble", 1'b1, found_flag);
    fall();
    rchk("status after fall", OFS_STATUS, ST_FD, ALL);
    set_src(32'h2491);
    rise();
    chk("found step2", 1'b0, found_flag);
    fall();
    source_word <= 32'h00f5;
    rise();
    chk("done step3", 1'b1, done_flag);
    rchk("status step3", OFS_STATUS, ST_EN | ST_DN | ST_FD, ALL);
    rchk("irq done event", OFS_IRQ_STATUS, 32'h1, 32'h1);
    chk("irq masked", 1'b0, irq);
    wr(OFS_IRQ_MASK, 32'h1);
    @(negedge ref_clk);
    chk("irq unmasked", 1'b1, irq);
    fall();
    wr(OFS_IRQ_STATUS, 32'h7);
    @(negedge ref_clk);
    chk("irq cleared", 1'b0, irq);
    rise();
    chk("done cleared", 1'b0, done_flag);
    rchk("position wraps", OFS_POSITION, 32'h1, ALL);
    fall();
    // Mask taken from the mask table at the current position
    wr(BASE_MASK_TAB + 12'h008, 32'h000f);
    wr(OFS_CONFIG, 32'h2);
    source_word <= 32'hfff4;
    rise();
    chk("found table mask", 1'b1, found_flag);
    fall();
    // Long words: a set top bit under an all-ones mask must count
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_IMM_MASK, ALL);
    wr(BASE_REF_TAB + 12'h00c, 32'h8000_00ff);
    source_word <= 32'h0000_00ff;
    rise();
    chk("found long word", 1'b0, found_flag);
    fall();
    // Refused lengths raise the error and the sticky fault, without a step
    foreach (bad_len[i]) begin
      wr(OFS_LENGTH, {16'h0, bad_len[i]});
      rise();
      chk("minor fault", 1'b1, minor_fault_flag);
      rchk("error bit", OFS_STATUS, ST_ER, ST_ER);
      rchk("position held", OFS_POSITION, 32'h3, ALL);
      fall();
    end
    wr(OFS_LENGTH, 32'h3);
    wr(OFS_STATUS, ST_ER);
    @(negedge ref_clk);
    chk("minor fault clear", 1'b0, minor_fault_flag);
    // Done is still set from the last step, so this rise restarts at one
    rise();
    rchk("restart after fault", OFS_POSITION, 32'h1, ALL);
    fall();
    // Position limit: 127 stops a long-word step, word data may go on
    // An empty mask keeps unloaded table entries out of the compare
    wr(OFS_IMM_MASK, 32'h0);
    wr(OFS_LENGTH, 32'hc8);
    wr(OFS_POSITION, 32'h7f);
    rise();
    chk("empty mask found", 1'b1, found_flag);
    rchk("long limit", OFS_POSITION, 32'h7f, ALL);
    chk("long limit error", 1'b1, minor_fault_flag);
    fall();
    wr(OFS_CONFIG, 32'h0);
    rise();
    rchk("word step", OFS_POSITION, 32'h80, ALL);
    rchk("word no error", OFS_STATUS, 32'h0, ST_ER);
    fall();
    finish_test();
  end

endmodule

`default_nettype wire
